// *** lpso_defines.vh ***
`ifndef LPSO_DEFINES_VH
`define LPSO_DEFINES_VH

// Register byte addresses
`define LPSO_OFF_FRAME_CFG 8'h0F
`define LPSO_OFF_DISP 8'h10
`define LPSO_OFF_BCNT 8'h11
`define LPSO_OFF_CCNT 8'h12
`define LPSO_OFF_FSTA 8'h13
`define LPSO_OFF_BOFS 8'h14
`define LPSO_OFF_ROFS 8'h15
`define LPSO_OFF_GOFS 8'h16
`define LPSO_OFF_BLOFS 8'h17
`define LPSO_OFF_STAT_W 8'h18
`define LPSO_OFF_OFS_W 8'h1C
`define LPSO_OFF_ROW_SEL 8'h20
`define LPSO_OFF_IRQ_MASK 8'h21
`define LPSO_OFF_CTRL 8'h22

// Display status fields
`define LPSO_BIT_FLAG 7
`define LPSO_BIT_FORCE 6
`define LPSO_BIT_IDLE 4

// Frame configuration fields
`define LPSO_INH_HI 7
`define LPSO_INH_LO 4
`define LPSO_REP_HI 2
`define LPSO_REP_LO 0

// Frame status fields
`define LPSO_FSTA_REP_HI 6
`define LPSO_FSTA_REP_LO 4
`define LPSO_FSTA_INH_HI 3
`define LPSO_FSTA_INH_LO 0

// Control fields
`define LPSO_BIT_RUN 0
`define LPSO_DIV_HI 2
`define LPSO_DIV_LO 1

// Counts and reset values
`define LPSO_CNT_MAX 8'hFF
`define LPSO_RST_BYTE 8'h00
`define LPSO_RST_WORD 32'h0000_0000
`define LPSO_RST_IDLE 1'b1
`define LPSO_RST_DIV 2'h0
`define LPSO_RST_REP 3'h0
`define LPSO_RST_INH 4'h0

`endif

// *** lpso_tick_div.v ***
`timescale 1ns/1ps
`include "lpso_defines.vh"

module lpso_tick_div (
  clk,
  nrst,
  en,
  div,
  tick
);
  input wire clk;
  input wire nrst;
  input wire en;
  input wire [1:0] div;
  output reg tick;

  reg [1:0] cnt_r;

  // Divide by div+1; one-cycle enable for the brightness reference
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= `LPSO_RST_DIV;
      tick <= 1'b0;
    end else if (!en) begin
      cnt_r <= `LPSO_RST_DIV;
      tick <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= `LPSO_RST_DIV;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      tick <= 1'b0;
    end
  end
endmodule

// *** lpso_ofs_add.v ***
`timescale 1ns/1ps
`include "lpso_defines.vh"

module lpso_ofs_add (
  clk,
  nrst,
  load,
  data,
  ofs,
  value_r
);
  input wire clk;
  input wire nrst;
  input wire load;
  input wire [7:0] data;
  input wire [7:0] ofs;
  output reg [7:0] value_r;

  wire [9:0] sum;

  assign sum = {2'b00, data} + {{2{ofs[7]}}, ofs};

  // Saturate rather than wrap, so a dim pixel never flips to full
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value_r <= `LPSO_RST_BYTE;
    end else if (load) begin
      if (sum[9]) begin
        value_r <= `LPSO_RST_BYTE;
      end else if (sum[8]) begin
        value_r <= `LPSO_CNT_MAX;
      end else begin
        value_r <= sum[7:0];
      end
    end
  end
endmodule

// *** lpso_status_offset.v ***
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "lpso_defines.vh"

module lpso_status_offset (
  clk,
  nrst,
  bus_addr,
  bus_wdata,
  bus_wr,
  bus_rd,
  bus_rdata,
  load_stb,
  load_bright,
  load_red,
  load_green,
  load_blue,
  row_sel,
  led_bright_on,
  led_red_on,
  led_green_on,
  led_blue_on,
  row_active,
  irq
);
  input wire clk;
  input wire nrst;
  input wire [7:0] bus_addr;
  input wire [31:0] bus_wdata;
  input wire bus_wr;
  input wire bus_rd;
  output reg [31:0] bus_rdata;
  input wire load_stb;
  input wire [7:0] load_bright;
  input wire [7:0] load_red;
  input wire [7:0] load_green;
  input wire [7:0] load_blue;
  output reg [7:0] row_sel;
  output reg led_bright_on;
  output reg led_red_on;
  output reg led_green_on;
  output reg led_blue_on;
  output reg row_active;
  output wire irq;

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PWM = 3'b010;
  localparam [2:0] ST_SWITCH = 3'b100;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function lit;
    input on;
    input [7:0] cnt;
    input [7:0] lvl;
    begin
      lit = on && (cnt < lvl);
    end
  endfunction

  // Software state
  reg [7:0] frame_cfg_r;
  reg [7:0] irq_mask_r;
  reg [7:0] ctrl_r;
  reg [31:0] ofs_r;
  reg flag_r;
  reg flag_nxt;

  // Sequencer state
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] bright_cnt_r;
  reg [7:0] colour_cnt_r;
  reg [2:0] repeat_idx_r;
  reg [3:0] switch_cnt_r;
  reg [7:0] bright_cnt_nxt;
  reg [7:0] colour_cnt_nxt;
  reg [2:0] repeat_idx_nxt;
  reg [3:0] switch_cnt_nxt;
  reg row_end;

  wire tick;
  wire run;
  wire bright_wrap;
  wire colour_wrap;
  wire [3:0] inh_set;
  wire [2:0] rep_set;
  wire wr_disp;
  wire wr_row_sel;
  wire wr_frame_cfg;
  wire wr_irq_mask;
  wire wr_ctrl;
  wire wr_bofs;
  wire wr_rofs;
  wire wr_gofs;
  wire wr_blofs;
  wire wr_ofs_w;
  wire flag_force_set;
  wire flag_w1c;
  wire in_pwm;
  wire [7:0] disp_byte;
  wire [7:0] fsta_byte;
  wire [31:0] stat_word;
  wire [31:0] ch_data;
  wire [31:0] ch_value;

  assign run = ctrl_r[`LPSO_BIT_RUN];
  assign inh_set = frame_cfg_r[`LPSO_INH_HI:`LPSO_INH_LO];
  assign rep_set = frame_cfg_r[`LPSO_REP_HI:`LPSO_REP_LO];
  assign bright_wrap = tick && (bright_cnt_r == `LPSO_CNT_MAX);
  assign colour_wrap = bright_wrap && (colour_cnt_r == `LPSO_CNT_MAX);
  assign wr_disp = bus_wr && (hit(bus_addr, `LPSO_OFF_DISP) || hit(bus_addr, `LPSO_OFF_STAT_W));
  assign wr_row_sel = bus_wr && hit(bus_addr, `LPSO_OFF_ROW_SEL);
  assign wr_frame_cfg = bus_wr && hit(bus_addr, `LPSO_OFF_FRAME_CFG);
  assign wr_irq_mask = bus_wr && hit(bus_addr, `LPSO_OFF_IRQ_MASK);
  assign wr_ctrl = bus_wr && hit(bus_addr, `LPSO_OFF_CTRL);
  assign wr_bofs = bus_wr && hit(bus_addr, `LPSO_OFF_BOFS);
  assign wr_rofs = bus_wr && hit(bus_addr, `LPSO_OFF_ROFS);
  assign wr_gofs = bus_wr && hit(bus_addr, `LPSO_OFF_GOFS);
  assign wr_blofs = bus_wr && hit(bus_addr, `LPSO_OFF_BLOFS);
  assign wr_ofs_w = bus_wr && hit(bus_addr, `LPSO_OFF_OFS_W);
  assign flag_force_set = wr_disp && bus_wdata[`LPSO_BIT_FORCE];
  assign flag_w1c = wr_disp && bus_wdata[`LPSO_BIT_FLAG];
  // One-hot state, so a single compare decides normal PWM
  assign in_pwm = (state_r == ST_PWM);

  lpso_tick_div u_div (
    .clk(clk),
    .nrst(nrst),
    .en(run),
    .div(ctrl_r[`LPSO_DIV_HI:`LPSO_DIV_LO]),
    .tick(tick)
  );

  // Register writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_cfg_r <= `LPSO_RST_BYTE;
      irq_mask_r <= `LPSO_RST_BYTE;
      ctrl_r <= `LPSO_RST_BYTE;
      ofs_r <= `LPSO_RST_WORD;
      row_sel <= `LPSO_RST_BYTE;
    end else if (bus_wr) begin
      if (wr_frame_cfg)
        frame_cfg_r <= bus_wdata[7:0];
      if (wr_irq_mask)
        irq_mask_r <= bus_wdata[7:0];
      if (wr_ctrl)
        ctrl_r <= bus_wdata[7:0];
      if (wr_row_sel)
        row_sel <= bus_wdata[7:0];
      if (wr_bofs)
        ofs_r[7:0] <= bus_wdata[7:0];
      if (wr_rofs)
        ofs_r[15:8] <= bus_wdata[7:0];
      if (wr_gofs)
        ofs_r[23:16] <= bus_wdata[7:0];
      if (wr_blofs)
        ofs_r[31:24] <= bus_wdata[7:0];
      if (wr_ofs_w)
        ofs_r <= bus_wdata;
    end
  end

  // Row-end flag: any set beats a clear in the same cycle
  always @* begin
    flag_nxt = flag_r;
    if (flag_w1c)
      flag_nxt = 1'b0;
    if (wr_row_sel)
      flag_nxt = 1'b0;
    if (row_end)
      flag_nxt = 1'b1;
    if (flag_force_set)
      flag_nxt = 1'b1;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign irq = flag_r && irq_mask_r[`LPSO_BIT_FLAG];

  // Scan sequencer
  always @* begin
    state_nxt = state_r;
    bright_cnt_nxt = bright_cnt_r;
    colour_cnt_nxt = colour_cnt_r;
    repeat_idx_nxt = repeat_idx_r;
    switch_cnt_nxt = switch_cnt_r;
    row_end = 1'b0;
    case (state_r)
      ST_IDLE: begin
        bright_cnt_nxt = `LPSO_RST_BYTE;
        colour_cnt_nxt = `LPSO_RST_BYTE;
        repeat_idx_nxt = `LPSO_RST_REP;
        switch_cnt_nxt = `LPSO_RST_INH;
        if (run)
          state_nxt = ST_PWM;
      end
      ST_PWM: begin
        if (tick)
          bright_cnt_nxt = bright_cnt_r + 8'h01;
        if (bright_wrap)
          colour_cnt_nxt = colour_cnt_r + 8'h01;
        if (colour_wrap) begin
          if (repeat_idx_r == rep_set) begin
            repeat_idx_nxt = `LPSO_RST_REP;
            switch_cnt_nxt = `LPSO_RST_INH;
            row_end = 1'b1;
            state_nxt = ST_SWITCH;
          end else begin
            repeat_idx_nxt = repeat_idx_r + 3'h1;
          end
        end
        if (!run)
          state_nxt = ST_IDLE;
      end
      ST_SWITCH: begin
        if (tick)
          bright_cnt_nxt = bright_cnt_r + 8'h01;
        if (bright_wrap) begin
          if (switch_cnt_r == inh_set) begin
            switch_cnt_nxt = `LPSO_RST_INH;
            colour_cnt_nxt = `LPSO_RST_BYTE;
            state_nxt = ST_PWM;
          end else begin
            switch_cnt_nxt = switch_cnt_r + 4'h1;
          end
        end
        if (!run)
          state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      bright_cnt_r <= `LPSO_RST_BYTE;
      colour_cnt_r <= `LPSO_RST_BYTE;
      repeat_idx_r <= `LPSO_RST_REP;
      switch_cnt_r <= `LPSO_RST_INH;
    end else begin
      state_r <= state_nxt;
      bright_cnt_r <= bright_cnt_nxt;
      colour_cnt_r <= colour_cnt_nxt;
      repeat_idx_r <= repeat_idx_nxt;
      switch_cnt_r <= switch_cnt_nxt;
    end
  end

  // Offset adders, one per channel: brightness, red, green, blue
  assign ch_data = {load_blue, load_green, load_red, load_bright};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
      lpso_ofs_add u_add (
        .clk(clk),
        .nrst(nrst),
        .load(load_stb),
        .data(ch_data[gi*8+7:gi*8]),
        .ofs(ofs_r[gi*8+7:gi*8]),
        .value_r(ch_value[gi*8+7:gi*8])
      );
    end
  endgenerate

  // Drive outputs; columns dark outside normal PWM
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led_bright_on <= 1'b0;
      led_red_on <= 1'b0;
      led_green_on <= 1'b0;
      led_blue_on <= 1'b0;
      row_active <= 1'b0;
    end else begin
      row_active <= in_pwm;
      led_bright_on <= lit(in_pwm, bright_cnt_r, ch_value[7:0]);
      led_red_on <= lit(in_pwm, colour_cnt_r, ch_value[15:8]);
      led_green_on <= lit(in_pwm, colour_cnt_r, ch_value[23:16]);
      led_blue_on <= lit(in_pwm, colour_cnt_r, ch_value[31:24]);
    end
  end

  // Read views
  assign disp_byte = {flag_r, 2'b00, ~in_pwm, 4'h0};
  assign fsta_byte = {1'b0, repeat_idx_r, switch_cnt_r};
  assign stat_word = {fsta_byte, colour_cnt_r, bright_cnt_r, disp_byte};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= `LPSO_RST_WORD;
    end else if (bus_rd) begin
      case (bus_addr)
        `LPSO_OFF_FRAME_CFG: bus_rdata <= {24'h000000, frame_cfg_r[7:4], 1'b0, frame_cfg_r[2:0]};
        `LPSO_OFF_DISP: bus_rdata <= {24'h000000, disp_byte};
        `LPSO_OFF_BCNT: bus_rdata <= {24'h000000, bright_cnt_r};
        `LPSO_OFF_CCNT: bus_rdata <= {24'h000000, colour_cnt_r};
        `LPSO_OFF_FSTA: bus_rdata <= {24'h000000, fsta_byte};
        `LPSO_OFF_BOFS: bus_rdata <= {24'h000000, ofs_r[7:0]};
        `LPSO_OFF_ROFS: bus_rdata <= {24'h000000, ofs_r[15:8]};
        `LPSO_OFF_GOFS: bus_rdata <= {24'h000000, ofs_r[23:16]};
        `LPSO_OFF_BLOFS: bus_rdata <= {24'h000000, ofs_r[31:24]};
        `LPSO_OFF_STAT_W: bus_rdata <= stat_word;
        `LPSO_OFF_OFS_W: bus_rdata <= ofs_r;
        `LPSO_OFF_ROW_SEL: bus_rdata <= {24'h000000, row_sel};
        `LPSO_OFF_IRQ_MASK: bus_rdata <= {24'h000000, irq_mask_r};
        `LPSO_OFF_CTRL: bus_rdata <= {24'h000000, ctrl_r};
        default: bus_rdata <= `LPSO_RST_WORD;
      endcase
    end else begin
      bus_rdata <= `LPSO_RST_WORD;
    end
  end
endmodule

// *** lpso_checker.sv ***
`timescale 1ns/1ps
`include "lpso_defines.vh"
module lpso_checker (
  input wire clk,
  input wire nrst,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire [7:0] row_sel,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd_disp = bus_rd && bus_addr == `LPSO_OFF_DISP;
  wire wr_disp = bus_wr && bus_addr == `LPSO_OFF_DISP;
  // Read data captures the flag before the edge, as irq does
  property p_irq;
    rd_disp ##1 !bus_rdata[`LPSO_BIT_FLAG] |-> !$past(irq);
  endproperty
  a_irq: assert property (p_irq) else $error("irq high with flag clear");
  property p_force;
    wr_disp && bus_wdata[`LPSO_BIT_FORCE] ##1 !bus_wr ##1 rd_disp |-> ##1 bus_rdata[`LPSO_BIT_FLAG];
  endproperty
  a_force: assert property (p_force) else $error("force did not set flag");
  // Only valid away from a row end, which the bench keeps
  property p_w1c;
    wr_disp && bus_wdata[7] && !bus_wdata[6] ##1 !bus_wr ##1 rd_disp |-> ##1 !bus_rdata[`LPSO_BIT_FLAG];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");
  property p_rowsel;
    bus_wr && bus_addr == `LPSO_OFF_ROW_SEL ##1 !bus_wr ##1 rd_disp |-> ##1 !bus_rdata[`LPSO_BIT_FLAG];
  endproperty
  a_rowsel: assert property (p_rowsel) else $error("row select left flag set");
  property p_rsv;
    rd_disp |=> bus_rdata[6:5] == 2'b00 && bus_rdata[3:0] == 4'h0 && bus_rdata[31:8] == 24'h000000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("status spare bits not zero");
  property p_fsta;
    bus_rd && bus_addr == `LPSO_OFF_FSTA |=> !bus_rdata[7] && bus_rdata[31:8] == 24'h000000;
  endproperty
  a_fsta: assert property (p_fsta) else $error("frame status spare bits set");
  property p_stand;
    !bus_rd |=> bus_rdata == 32'h00000000;
  endproperty
  a_stand: assert property (p_stand) else $error("read data outside its cycle");
  property p_rst;
    $rose(nrst) |-> !irq && row_sel == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind lpso_status_offset lpso_checker chk_u (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .row_sel(row_sel), .irq(irq));

// *** lpso_led_model.sv ***
`timescale 1ns/1ps
module lpso_led_model (
  input wire clk,
  input wire clr,
  input wire row_active,
  input wire on_b,
  input wire on_r,
  input wire on_g,
  input wire on_bl,
  output reg [15:0] n_b,
  output reg [15:0] n_r,
  output reg [15:0] n_g,
  output reg [15:0] n_bl
);
  // Lit cycles per column; a dark row adds nothing
  always @(posedge clk) begin
    if (clr) begin
      n_b <= 16'h0000;
      n_r <= 16'h0000;
      n_g <= 16'h0000;
      n_bl <= 16'h0000;
    end else if (row_active) begin
      n_b <= n_b + {15'h0000, on_b};
      n_r <= n_r + {15'h0000, on_r};
      n_g <= n_g + {15'h0000, on_g};
      n_bl <= n_bl + {15'h0000, on_bl};
    end
  end
endmodule

// *** lpso_tb.sv ***
`timescale 1ns/1ps
`include "lpso_defines.vh"
module testbench;
  reg clk, nrst, bus_wr, bus_rd, load_stb, clr;
  reg [7:0] bus_addr, ld_b, ld_r, ld_g, ld_bl;
  reg [31:0] bus_wdata, d, e;
  wire [31:0] bus_rdata;
  wire [7:0] row_sel;
  wire irq, row_active, on_b, on_r, on_g, on_bl;
  wire [15:0] n_b, n_r, n_g, n_bl;
  integer err_count, tests_run, i;
  lpso_status_offset dut_u (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .load_stb(load_stb), .load_bright(ld_b), .load_red(ld_r),
    .load_green(ld_g), .load_blue(ld_bl), .row_sel(row_sel), .led_bright_on(on_b), .led_red_on(on_r),
    .led_green_on(on_g), .led_blue_on(on_bl), .row_active(row_active), .irq(irq));
  lpso_led_model led_u (.clk(clk), .clr(clr), .row_active(row_active), .on_b(on_b), .on_r(on_r), .on_g(on_g),
    .on_bl(on_bl), .n_b(n_b), .n_r(n_r), .n_g(n_g), .n_bl(n_bl));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task results;
    begin
      $display("mismatches %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge clk);
      bus_wr <= 1'b0;
    end
  endtask
  // Sample at the falling edge: data stands one cycle only
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      d = bus_rdata;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      rd(a);
      chk(d, exp);
    end
  endtask
  task ichk(input v);
    begin
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, v});
    end
  endtask
  initial begin
    {nrst, bus_wr, bus_rd, load_stb, clr} = 5'h00;
    {bus_addr, bus_wdata, ld_b, ld_r, ld_g, ld_bl} = 72'h0;
    err_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rchk(`LPSO_OFF_DISP, 32'h10);
    rchk(`LPSO_OFF_CCNT, 32'h0);
    rchk(`LPSO_OFF_FSTA, 32'h0);
    rchk(`LPSO_OFF_OFS_W, 32'h0);
    rchk(8'h30, 32'h0);
    wr(`LPSO_OFF_IRQ_MASK, 32'h80);
    wr(`LPSO_OFF_DISP, 32'h40);
    rchk(`LPSO_OFF_DISP, 32'h90);
    ichk(1'b1);
    wr(`LPSO_OFF_DISP, 32'h80);
    rchk(`LPSO_OFF_DISP, 32'h10);
    ichk(1'b0);
    wr(`LPSO_OFF_DISP, 32'h40);
    wr(`LPSO_OFF_IRQ_MASK, 32'h00);
    ichk(1'b0);
    wr(`LPSO_OFF_ROW_SEL, 32'h5A);
    rchk(`LPSO_OFF_DISP, 32'h10);
    chk({24'h0, row_sel}, 32'h5A);
    wr(`LPSO_OFF_IRQ_MASK, 32'h80);
    wr(`LPSO_OFF_OFS_W, 32'h007FF010);
    wr(`LPSO_OFF_BLOFS, 32'h80);
    rchk(`LPSO_OFF_ROFS, 32'hF0);
    rchk(`LPSO_OFF_OFS_W, 32'h807FF010);
    // Edge sums: red lands on zero, green lifted from zero, blue clamps at zero
    @(posedge clk);
    {load_stb, ld_b, ld_r, ld_g, ld_bl} <= 33'h1_4010_0005;
    @(posedge clk);
    load_stb <= 1'b0;
    wr(`LPSO_OFF_FRAME_CFG, 32'h10);
    wr(`LPSO_OFF_CTRL, 32'h01);
    repeat (16) @(posedge clk);
    rchk(`LPSO_OFF_DISP, 32'h00);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (256) @(posedge clk);
    @(negedge clk);
    chk({16'h0, n_b}, 32'h50);
    chk({16'h0, n_r}, 32'h0);
    chk({16'h0, n_g}, 32'h100);
    chk({16'h0, n_bl}, 32'h0);
    rd(`LPSO_OFF_BCNT);
    e = d;
    rchk(`LPSO_OFF_BCNT, {24'h0, e[7:0] + 8'h02});
    rd(`LPSO_OFF_STAT_W);
    e = d;
    repeat (254) @(posedge clk);
    rd(`LPSO_OFF_STAT_W);
    chk(d, {e[31:24], e[23:16] + 8'h01, e[15:0]});
    chk({24'h0, e[7:0]}, 32'h0);
    rchk(`LPSO_OFF_BCNT, {24'h0, d[15:8] + 8'h02});
    d = 32'h0;
    for (i = 0; i < 40000 && d[7] !== 1'b1; i = i + 1) rd(`LPSO_OFF_DISP);
    if (d[7] !== 1'b1) begin
      err_count = err_count + 1;
      results;
    end
    chk(d, 32'h90);
    ichk(1'b1);
    rchk(`LPSO_OFF_FSTA, 32'h00);
    repeat (254) @(posedge clk);
    rchk(`LPSO_OFF_FSTA, 32'h01);
    repeat (260) @(posedge clk);
    rchk(`LPSO_OFF_DISP, 32'h80);
    wr(`LPSO_OFF_ROW_SEL, 32'h01);
    rchk(`LPSO_OFF_DISP, 32'h00);
    ichk(1'b0);
    results;
  end
endmodule
